// ===== rtl/exc_entry_pkg.sv
// Constants and types for the exception entry and return unit
// Notes on behaviour
// - Reset vector 0, undefined 4, software 8
// - Prefetch 0xc, data 0x10, irq 0x18, fiq 0x1c
// - Slot 0x14 reserved, never taken here
// - Entry saves link, status, mode, mask, vector
// - Fast mask set on entry only by reset, fast
// - Return copies saved status and link back
// - Reset aborts instruction; entry after release
// - Reset release: supervisor, both masks, fetch 0
// - Unacknowledged coprocessor instruction becomes undefined
// - Undefined encoding takes undefined exception
// - Undefined entry: link plus four, mode 0b011011
// - Software interrupt: link plus four, supervisor
// - Fetch abort taken only when executed
// - Prefetch abort: link plus four, abort mode
// - Data abort: link plus eight, abort mode
// - Data abort entered before later state changes
// - Base writeback choice same for all
// - Normal interrupt sampled at boundary, unmasked
// - Masks writable only in privileged modes
// - Interrupt entry: next plus four, 0b010010
// - Fast interrupt sampled at boundary, unmasked
// - Fast entry: next plus four, both masks
// - Priority: reset, data, fast, normal, prefetch, undefined
package exc_entry_pkg;
  localparam logic [31:0] VecReset    = 32'h0000_0000;
  localparam logic [31:0] VecUndef    = 32'h0000_0004;
  localparam logic [31:0] VecSwi      = 32'h0000_0008;
  localparam logic [31:0] VecPabort   = 32'h0000_000c;
  localparam logic [31:0] VecDabort   = 32'h0000_0010;
  localparam logic [31:0] VecAddrRsvd = 32'h0000_0014;
  localparam logic [31:0] VecIrq      = 32'h0000_0018;
  localparam logic [31:0] VecFiq      = 32'h0000_001c;
  localparam logic [5:0]  ModeUser    = 6'h10;
  localparam logic [5:0]  ModeFiq     = 6'h11;
  localparam logic [5:0]  ModeIrq     = 6'h12;
  localparam logic [5:0]  ModeSvc     = 6'h13;
  localparam logic [5:0]  ModeAbt     = 6'h17;
  localparam logic [5:0]  ModeUnd     = 6'h1b;
  localparam logic [5:0]  ModeSys     = 6'h1f;
  localparam int          ModeLsb     = 0;
  localparam int          FastMaskBit = 6;
  localparam int          IrqMaskBit  = 7;
  localparam logic [31:0] LinkOff4    = 32'h0000_0004;
  localparam logic [31:0] LinkOff8    = 32'h0000_0008;
  localparam logic [31:0] StatusRst   = 32'h0000_00d3;
  // Base value left in the base register after an aborted writeback
  localparam bit          KeepUpdatedBase = 1'b0;

  typedef enum logic [2:0] {
    ExcNone   = 3'b000,
    ExcReset  = 3'b001,
    ExcDabort = 3'b010,
    ExcFiq    = 3'b011,
    ExcIrq    = 3'b100,
    ExcPabort = 3'b101,
    ExcUndef  = 3'b110,
    ExcSwi    = 3'b111
  } exc_t;

  typedef enum logic [1:0] {
    StRun    = 2'b00,
    StCopWait = 2'b01,
    StResetHold = 2'b10
  } state_t;

  // Instruction presented by the pipeline at an execute boundary
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        fetchAbort;
    logic        isUndef;
    logic        isSwi;
    logic        isCop;
  } instr_t;

  // Return request from the pipeline
  typedef struct packed {
    logic        valid;
    logic [31:0] link;
  } ret_t;
endpackage : exc_entry_pkg

// ===== rtl/processor_exception_entry.sv
// Exception entry, priority and return logic of the processor core
`timescale 1ns/1ps
module processor_exception_entry #(
  parameter int CopTimeout = 4
) (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // Pipeline
  input  wire exc_entry_pkg::instr_t instr,
  input  wire logic                  dataAbort,
  input  wire logic [31:0]           dataAbortAddr,
  input  wire exc_entry_pkg::ret_t   excReturn,
  input  wire logic                  maskWrite,
  input  wire logic [1:0]            maskWriteData,
  // External requests, from pins
  input  wire logic                  irqReq,
  input  wire logic                  fiqReq,
  input  wire logic                  copAck,
  // Results
  output logic                       fetchRedirect,
  output logic [31:0]                fetchAddr,
  output logic [31:0]                current_status_word,
  output logic [31:0]                supervisor_link_register,
  output logic [31:0]                undefined_link_register,
  output logic [31:0]                abort_link_register,
  output logic [31:0]                interrupt_link_register,
  output logic [31:0]                fast_link_register,
  output logic [31:0]                supervisor_saved_status,
  output logic [31:0]                undefined_saved_status,
  output logic [31:0]                abort_saved_status,
  output logic [31:0]                interrupt_saved_status,
  output logic [31:0]                fast_saved_status,
  output logic                       instrRetire,
  output exc_entry_pkg::exc_t        excTaken
);
  // Pin synchronisers: three stages, change accepted when stages two and three agree
  logic [2:0] irqSync_r, fiqSync_r, ackSync_r;
  logic       irqLvl_r, fiqLvl_r, ackLvl_r;
  logic [2:0] irqSync_nxt, fiqSync_nxt, ackSync_nxt;
  logic       irqLvl_nxt, fiqLvl_nxt, ackLvl_nxt;

  always_comb begin
    irqSync_nxt = {irqSync_r[1:0], irqReq};
    fiqSync_nxt = {fiqSync_r[1:0], fiqReq};
    ackSync_nxt = {ackSync_r[1:0], copAck};
    irqLvl_nxt  = (irqSync_r[1] == irqSync_r[2]) ? irqSync_r[2] : irqLvl_r;
    fiqLvl_nxt  = (fiqSync_r[1] == fiqSync_r[2]) ? fiqSync_r[2] : fiqLvl_r;
    ackLvl_nxt  = (ackSync_r[1] == ackSync_r[2]) ? ackSync_r[2] : ackLvl_r;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      irqSync_r <= 3'h0;
      fiqSync_r <= 3'h0;
      ackSync_r <= 3'h0;
      irqLvl_r  <= 1'b0;
      fiqLvl_r  <= 1'b0;
      ackLvl_r  <= 1'b0;
    end else begin
      irqSync_r <= irqSync_nxt;
      fiqSync_r <= fiqSync_nxt;
      ackSync_r <= ackSync_nxt;
      irqLvl_r  <= irqLvl_nxt;
      fiqLvl_r  <= fiqLvl_nxt;
      ackLvl_r  <= ackLvl_nxt;
    end
  end

  // Main state
  exc_entry_pkg::state_t state_r, state_nxt;
  logic [31:0] status_r, status_nxt;
  logic [31:0] copAddr_r, copAddr_nxt;
  logic [31:0] lrSvc_r, lrUnd_r, lrAbt_r, lrIrq_r, lrFiq_r;
  logic [31:0] lrSvc_nxt, lrUnd_nxt, lrAbt_nxt, lrIrq_nxt, lrFiq_nxt;
  logic [31:0] spSvc_r, spUnd_r, spAbt_r, spIrq_r, spFiq_r;
  logic [31:0] spSvc_nxt, spUnd_nxt, spAbt_nxt, spIrq_nxt, spFiq_nxt;
  logic        redir_r, redir_nxt, retire_r, retire_nxt;
  logic [31:0] fAddr_r, fAddr_nxt;
  logic [7:0]  copCnt_r, copCnt_nxt;
  exc_entry_pkg::exc_t taken_r, taken_nxt;

  logic        privileged, boundary, copFail;
  exc_entry_pkg::exc_t sel;
  logic [31:0] link, savedSel, vec;
  logic [5:0]  mode;

  always_comb begin
    privileged = status_r[5:0] != exc_entry_pkg::ModeUser;
    // Boundary: an instruction is at execute and not stalled on a coprocessor
    boundary   = instr.valid && state_r == exc_entry_pkg::StRun;
    copFail    = state_r == exc_entry_pkg::StCopWait && !ackLvl_r
                 && copCnt_r == 8'(CopTimeout);
    // Fixed priority, highest first
    if (dataAbort)
      sel = exc_entry_pkg::ExcDabort;
    else if (boundary && fiqLvl_r && !status_r[exc_entry_pkg::FastMaskBit])
      sel = exc_entry_pkg::ExcFiq;
    else if (boundary && irqLvl_r && !status_r[exc_entry_pkg::IrqMaskBit])
      sel = exc_entry_pkg::ExcIrq;
    else if (boundary && instr.fetchAbort)
      sel = exc_entry_pkg::ExcPabort;
    else if ((boundary && instr.isUndef) || copFail)
      sel = exc_entry_pkg::ExcUndef;
    else if (boundary && instr.isSwi)
      sel = exc_entry_pkg::ExcSwi;
    else
      sel = exc_entry_pkg::ExcNone;
  end

  always_comb begin
    // A timed-out coprocessor instruction has left execute: use its latched address
    link = (state_r == exc_entry_pkg::StCopWait ? copAddr_r : instr.addr)
           + exc_entry_pkg::LinkOff4;
    mode = exc_entry_pkg::ModeSvc;
    vec  = exc_entry_pkg::VecReset;
    case (sel)
      exc_entry_pkg::ExcDabort: begin
        link = dataAbortAddr + exc_entry_pkg::LinkOff8;
        // Original base value kept, alike for every access kind
        mode = exc_entry_pkg::ModeAbt;
        vec  = exc_entry_pkg::VecDabort;
      end
      exc_entry_pkg::ExcFiq: begin
        mode = exc_entry_pkg::ModeFiq;
        vec  = exc_entry_pkg::VecFiq;
      end
      exc_entry_pkg::ExcIrq: begin
        mode = exc_entry_pkg::ModeIrq;
        vec  = exc_entry_pkg::VecIrq;
      end
      exc_entry_pkg::ExcPabort: begin
        mode = exc_entry_pkg::ModeAbt;
        vec  = exc_entry_pkg::VecPabort;
      end
      exc_entry_pkg::ExcUndef: begin
        mode = exc_entry_pkg::ModeUnd;
        vec  = exc_entry_pkg::VecUndef;
      end
      exc_entry_pkg::ExcSwi: begin
        mode = exc_entry_pkg::ModeSvc;
        vec  = exc_entry_pkg::VecSwi;
      end
      default: begin
        mode = exc_entry_pkg::ModeSvc;
        vec  = exc_entry_pkg::VecReset;
      end
    endcase
    // Saved status of the current mode, used by an exception return
    case (status_r[5:0])
      exc_entry_pkg::ModeSvc: savedSel = spSvc_r;
      exc_entry_pkg::ModeUnd: savedSel = spUnd_r;
      exc_entry_pkg::ModeAbt: savedSel = spAbt_r;
      exc_entry_pkg::ModeIrq: savedSel = spIrq_r;
      exc_entry_pkg::ModeFiq: savedSel = spFiq_r;
      default:                savedSel = status_r;
    endcase
  end

  always_comb begin
    state_nxt  = state_r;
    status_nxt = status_r;
    copAddr_nxt = copAddr_r;
    {lrSvc_nxt, lrUnd_nxt, lrAbt_nxt, lrIrq_nxt, lrFiq_nxt} =
      {lrSvc_r, lrUnd_r, lrAbt_r, lrIrq_r, lrFiq_r};
    {spSvc_nxt, spUnd_nxt, spAbt_nxt, spIrq_nxt, spFiq_nxt} =
      {spSvc_r, spUnd_r, spAbt_r, spIrq_r, spFiq_r};
    redir_nxt  = 1'b0;
    retire_nxt = 1'b0;
    fAddr_nxt  = fAddr_r;
    taken_nxt  = exc_entry_pkg::ExcNone;
    copCnt_nxt = 8'h00;
    case (state_r)
      exc_entry_pkg::StResetHold: begin
        // Entry performed only once reset has gone
        spSvc_nxt  = status_r;
        status_nxt = {status_r[31:8], 2'b11, exc_entry_pkg::ModeSvc};
        redir_nxt = 1'b1;
        fAddr_nxt = exc_entry_pkg::VecReset;
        taken_nxt = exc_entry_pkg::ExcReset;
        state_nxt = exc_entry_pkg::StRun;
      end
      exc_entry_pkg::StRun, exc_entry_pkg::StCopWait: begin
        if (state_r == exc_entry_pkg::StCopWait)
          copCnt_nxt = copCnt_r + 8'h01;
        if (sel != exc_entry_pkg::ExcNone) begin
          case (mode)
            exc_entry_pkg::ModeUnd: begin lrUnd_nxt = link; spUnd_nxt = status_r; end
            exc_entry_pkg::ModeAbt: begin lrAbt_nxt = link; spAbt_nxt = status_r; end
            exc_entry_pkg::ModeIrq: begin lrIrq_nxt = link; spIrq_nxt = status_r; end
            exc_entry_pkg::ModeFiq: begin lrFiq_nxt = link; spFiq_nxt = status_r; end
            default:                begin lrSvc_nxt = link; spSvc_nxt = status_r; end
          endcase
          status_nxt[5:0] = mode;
          status_nxt[exc_entry_pkg::IrqMaskBit] = 1'b1;
          if (sel == exc_entry_pkg::ExcFiq)
            status_nxt[exc_entry_pkg::FastMaskBit] = 1'b1;
          redir_nxt = 1'b1;
          fAddr_nxt = vec;
          taken_nxt = sel;
          state_nxt = exc_entry_pkg::StRun;
        end else if (state_r == exc_entry_pkg::StCopWait) begin
          if (ackLvl_r) begin
            retire_nxt = 1'b1;
            state_nxt  = exc_entry_pkg::StRun;
          end
        end else if (excReturn.valid) begin
          status_nxt = savedSel;
          redir_nxt  = 1'b1;
          fAddr_nxt  = excReturn.link;
        end else if (boundary && instr.isCop) begin
          state_nxt   = exc_entry_pkg::StCopWait;
          copAddr_nxt = instr.addr;
        end else begin
          retire_nxt = boundary;
          if (maskWrite && privileged)
            status_nxt[7:6] = maskWriteData;
        end
      end
      default: state_nxt = exc_entry_pkg::StRun;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= exc_entry_pkg::StResetHold;
      status_r  <= exc_entry_pkg::StatusRst;
      copAddr_r <= 32'h0000_0000;
      {lrSvc_r, lrUnd_r, lrAbt_r, lrIrq_r, lrFiq_r} <= '0;
      {spSvc_r, spUnd_r, spAbt_r, spIrq_r, spFiq_r} <= '0;
      redir_r  <= 1'b0;
      retire_r <= 1'b0;
      fAddr_r  <= exc_entry_pkg::VecReset;
      copCnt_r <= 8'h00;
      taken_r  <= exc_entry_pkg::ExcNone;
    end else begin
      state_r <= state_nxt;
      status_r  <= status_nxt;
      copAddr_r <= copAddr_nxt;
      {lrSvc_r, lrUnd_r, lrAbt_r, lrIrq_r, lrFiq_r} <=
        {lrSvc_nxt, lrUnd_nxt, lrAbt_nxt, lrIrq_nxt, lrFiq_nxt};
      {spSvc_r, spUnd_r, spAbt_r, spIrq_r, spFiq_r} <=
        {spSvc_nxt, spUnd_nxt, spAbt_nxt, spIrq_nxt, spFiq_nxt};
      redir_r  <= redir_nxt;
      retire_r <= retire_nxt;
      fAddr_r  <= fAddr_nxt;
      copCnt_r <= copCnt_nxt;
      taken_r  <= taken_nxt;
    end
  end

  always_comb begin
    fetchRedirect            = redir_r;
    fetchAddr                = fAddr_r;
    current_status_word      = status_r;
    supervisor_link_register = lrSvc_r;
    undefined_link_register  = lrUnd_r;
    abort_link_register      = lrAbt_r;
    interrupt_link_register  = lrIrq_r;
    fast_link_register       = lrFiq_r;
    supervisor_saved_status  = spSvc_r;
    undefined_saved_status   = spUnd_r;
    abort_saved_status       = spAbt_r;
    interrupt_saved_status   = spIrq_r;
    fast_saved_status        = spFiq_r;
    instrRetire              = retire_r;
    excTaken                 = taken_r;
  end

  // Checks
  sequence dabortSeen;
    dataAbort;
  endsequence
  sequence dabortEntry;
    ##1 fetchAddr == exc_entry_pkg::VecDabort && fetchRedirect
        && current_status_word[5:0] == exc_entry_pkg::ModeAbt;
  endsequence
  dabort_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
    dabortSeen |-> dabortEntry) else $error("data abort entry wrong");
  dabort_link_a: assert property (@(posedge sys_clk) disable iff (reset)
    dataAbort |=> abort_link_register == $past(dataAbortAddr) + 32'h8)
    else $error("data abort link wrong");
  reset_entry_a: assert property (@(posedge sys_clk)
    $fell(reset) |=> excTaken == exc_entry_pkg::ExcReset && fetchAddr == 32'h0
      && current_status_word[7:0] == 8'hd3) else $error("reset entry wrong");
  fiq_mask_a: assert property (@(posedge sys_clk) disable iff (reset)
    excTaken inside {exc_entry_pkg::ExcIrq, exc_entry_pkg::ExcSwi,
      exc_entry_pkg::ExcUndef, exc_entry_pkg::ExcPabort}
      |-> current_status_word[6] == $past(current_status_word[6]))
    else $error("fast mask changed");
  irq_masked_a: assert property (@(posedge sys_clk) disable iff (reset)
    excTaken == exc_entry_pkg::ExcIrq |-> !$past(current_status_word[7]))
    else $error("masked interrupt taken");
  fiq_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
    excTaken == exc_entry_pkg::ExcFiq |-> fetchAddr == 32'h1c
      && current_status_word[7:6] == 2'b11) else $error("fast entry wrong");
  user_mask_a: assert property (@(posedge sys_clk) disable iff (reset)
    current_status_word[5:0] == exc_entry_pkg::ModeUser && maskWrite
      |=> excTaken != exc_entry_pkg::ExcNone
      || current_status_word[7:6] == $past(current_status_word[7:6]))
    else $error("user mode changed masks");
  swi_entry_a: assert property (@(posedge sys_clk) disable iff (reset)
    excTaken == exc_entry_pkg::ExcSwi |-> fetchAddr == 32'h8
      && current_status_word[5:0] == 6'h13) else $error("software entry wrong");
  no_rsvd_a: assert property (@(posedge sys_clk) disable iff (reset)
    !(fetchRedirect && fetchAddr == exc_entry_pkg::VecAddrRsvd))
    else $error("reserved slot used");
endmodule : processor_exception_entry

// ===== test/exc_far_side.sv
// Far-side model: interrupt request pins and an external coprocessor
`timescale 1ns/1ps
module exc_far_side (
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  // Commands from the bench
  input  wire logic                  irqOn,
  input  wire logic                  fiqOn,
  input  wire logic                  copWilling,
  // Instruction stream watched by the coprocessor
  input  wire exc_entry_pkg::instr_t instr,
  // Pins toward the core
  output logic                       irqReq,
  output logic                       fiqReq,
  output logic                       copAck
);
  logic [2:0] ackCnt_r;
  logic [2:0] ackCnt_nxt;

  // Request sources hold their level until the bench withdraws it
  assign irqReq = irqOn;
  assign fiqReq = fiqOn;

  always_comb begin
    ackCnt_nxt = (ackCnt_r == 3'h0) ? 3'h0 : ackCnt_r - 3'h1;
    if (instr.valid && instr.isCop && copWilling) begin
      ackCnt_nxt = 3'h4;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ackCnt_r <= 3'h0;
    end else begin
      ackCnt_r <= ackCnt_nxt;
    end
  end

  // Acknowledge arrives late and lasts two cycles only
  assign copAck = (ackCnt_r == 3'h1) || (ackCnt_r == 3'h2);
endmodule : exc_far_side

// ===== test/processor_exception_entry_tb.sv
// Self-checking bench for the exception entry and return unit
`timescale 1ns/1ps
module processor_exception_entry_tb;
  localparam int CopWait = 8;
  logic                  sys_clk;
  logic                  reset;
  exc_entry_pkg::instr_t instr;
  logic                  dataAbort;
  logic [31:0]           dataAbortAddr;
  exc_entry_pkg::ret_t   excReturn;
  logic                  maskWrite;
  logic [1:0]            maskWriteData;
  logic                  irqReq, fiqReq, copAck, irqOn, fiqOn, copWilling;
  logic                  fetchRedirect, instrRetire;
  logic [31:0]           fetchAddr, current_status_word;
  logic [31:0]           supervisor_link_register, undefined_link_register;
  logic [31:0]           abort_link_register, interrupt_link_register, fast_link_register;
  logic [31:0]           supervisor_saved_status, undefined_saved_status;
  logic [31:0]           abort_saved_status, interrupt_saved_status, fast_saved_status;
  exc_entry_pkg::exc_t   excTaken;
  int                    seed, failures, samples_checked, cycles, k;
  logic [31:0]           a, expStatus, savedExp;
  exc_entry_pkg::exc_t   kindTab [4] = '{exc_entry_pkg::ExcUndef, exc_entry_pkg::ExcSwi,
                                         exc_entry_pkg::ExcPabort, exc_entry_pkg::ExcDabort};

  processor_exception_entry #(.CopTimeout(CopWait)) DUT (
    .sys_clk(sys_clk), .reset(reset), .instr(instr), .dataAbort(dataAbort),
    .dataAbortAddr(dataAbortAddr), .excReturn(excReturn), .maskWrite(maskWrite),
    .maskWriteData(maskWriteData), .irqReq(irqReq), .fiqReq(fiqReq), .copAck(copAck),
    .fetchRedirect(fetchRedirect), .fetchAddr(fetchAddr),
    .current_status_word(current_status_word),
    .supervisor_link_register(supervisor_link_register),
    .undefined_link_register(undefined_link_register),
    .abort_link_register(abort_link_register),
    .interrupt_link_register(interrupt_link_register),
    .fast_link_register(fast_link_register),
    .supervisor_saved_status(supervisor_saved_status),
    .undefined_saved_status(undefined_saved_status),
    .abort_saved_status(abort_saved_status),
    .interrupt_saved_status(interrupt_saved_status),
    .fast_saved_status(fast_saved_status), .instrRetire(instrRetire), .excTaken(excTaken));
  exc_far_side far (.sys_clk(sys_clk), .reset(reset), .irqOn(irqOn), .fiqOn(fiqOn),
    .copWilling(copWilling), .instr(instr), .irqReq(irqReq), .fiqReq(fiqReq), .copAck(copAck));

  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // The reserved slot must never appear as a redirect target
  always @(posedge sys_clk) begin
    #1;
    if (fetchRedirect === 1'b1) check("rsvd", {31'h0, fetchAddr === 32'h14}, 32'h0);
  end

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step

  function automatic logic [31:0] rnd();
    rnd = $random(seed) & 32'hffff_fffc;
  endfunction : rnd

  task automatic idle();
    instr = '0;
    dataAbort = 1'b0;
    excReturn = '0;
    maskWrite = 1'b0;
  endtask : idle

  // Flags are {fetchAbort, isUndef, isSwi, isCop}
  task automatic present(input logic [3:0] f, input logic [31:0] ad);
    instr = {1'b1, ad, f};
  endtask : present

  function automatic logic [37:0] info(input exc_entry_pkg::exc_t kind);
    case (kind)
      exc_entry_pkg::ExcReset:  info = {exc_entry_pkg::ModeSvc, exc_entry_pkg::VecReset};
      exc_entry_pkg::ExcUndef:  info = {exc_entry_pkg::ModeUnd, exc_entry_pkg::VecUndef};
      exc_entry_pkg::ExcSwi:    info = {exc_entry_pkg::ModeSvc, exc_entry_pkg::VecSwi};
      exc_entry_pkg::ExcPabort: info = {exc_entry_pkg::ModeAbt, exc_entry_pkg::VecPabort};
      exc_entry_pkg::ExcDabort: info = {exc_entry_pkg::ModeAbt, exc_entry_pkg::VecDabort};
      exc_entry_pkg::ExcIrq:    info = {exc_entry_pkg::ModeIrq, exc_entry_pkg::VecIrq};
      default:                  info = {exc_entry_pkg::ModeFiq, exc_entry_pkg::VecFiq};
    endcase
  endfunction : info

  task automatic entryCheck(input exc_entry_pkg::exc_t kind, input logic [31:0] linkExp);
    logic [37:0] inf;
    logic [31:0] lnk;
    logic [31:0] sav;
    logic        fast;
    inf = info(kind);
    fast = (kind == exc_entry_pkg::ExcReset) || (kind == exc_entry_pkg::ExcFiq);
    case (kind)
      exc_entry_pkg::ExcUndef: lnk = undefined_link_register;
      exc_entry_pkg::ExcIrq:   lnk = interrupt_link_register;
      exc_entry_pkg::ExcFiq:   lnk = fast_link_register;
      exc_entry_pkg::ExcSwi:   lnk = supervisor_link_register;
      default:                 lnk = abort_link_register;
    endcase
    case (kind)
      exc_entry_pkg::ExcUndef: sav = undefined_saved_status;
      exc_entry_pkg::ExcIrq:   sav = interrupt_saved_status;
      exc_entry_pkg::ExcFiq:   sav = fast_saved_status;
      exc_entry_pkg::ExcPabort, exc_entry_pkg::ExcDabort: sav = abort_saved_status;
      default:                 sav = supervisor_saved_status;
    endcase
    check("redirect", {31'h0, fetchRedirect}, 32'h1);
    check("vector", fetchAddr, inf[31:0]);
    check("kind", {29'h0, excTaken}, {29'h0, kind});
    if (kind != exc_entry_pkg::ExcReset) begin
      check("link", lnk, linkExp);
    end
    check("saved", sav, expStatus);
    savedExp = expStatus;
    expStatus = {expStatus[31:8], 1'b1, expStatus[6] | fast, inf[37:32]};
    check("status", current_status_word, expStatus);
  endtask : entryCheck

  task automatic doReturn();
    logic [31:0] l;
    l = rnd();
    excReturn = {1'b1, l};
    step();
    excReturn = '0;
    check("ret redirect", {31'h0, fetchRedirect}, 32'h1);
    check("ret addr", fetchAddr, l);
    expStatus = savedExp;
    check("ret status", current_status_word, expStatus);
  endtask : doReturn

  // Offers plain instructions until an exception answers; returns the last address
  task automatic waitExc(output logic [31:0] ad);
    int n;
    n = 0;
    do begin
      ad = rnd();
      present(4'h0, ad);
      step();
      n++;
    end while (excTaken === exc_entry_pkg::ExcNone && n < 12);
    idle();
  endtask : waitExc

  task automatic waitAnswer();
    int n;
    n = 0;
    while (excTaken === exc_entry_pkg::ExcNone && instrRetire !== 1'b1 && n < 20) begin
      step();
      n++;
    end
  endtask : waitAnswer

  initial begin
    seed = 70808;
    failures = 0;
    samples_checked = 0;
    cycles = 0;
    reset = 1'b1;
    {irqOn, fiqOn, copWilling} = 3'b000;
    dataAbortAddr = '0;
    maskWriteData = 2'b00;
    idle();
    repeat (20) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    step();
    expStatus = exc_entry_pkg::StatusRst;
    entryCheck(exc_entry_pkg::ExcReset, 32'h0);
    $display("test reset entry done");
    irqOn = 1'b1;
    repeat (12) begin
      present(4'h0, rnd());
      step();
      check("masked irq", {29'h0, excTaken}, {29'h0, exc_entry_pkg::ExcNone});
      check("retire", {31'h0, instrRetire}, 32'h1);
    end
    idle();
    irqOn = 1'b0;
    repeat (6) step();
    maskWrite = 1'b1;
    step();
    idle();
    expStatus[7:6] = 2'b00;
    check("mask write", current_status_word, expStatus);
    $display("test masked interrupt and mask write done");
    repeat (12) begin
      k = $random(seed) & 3;
      a = rnd();
      case (k)
        0: present(4'b0100, a);
        1: present(4'b0010, a);
        2: present(4'b1100, a);
        default: begin
          present(4'b0010, rnd());
          dataAbort = 1'b1;
          dataAbortAddr = a;
        end
      endcase
      step();
      idle();
      entryCheck(kindTab[k], a + ((k == 3) ? 32'h8 : 32'h4));
      doReturn();
    end
    $display("test synchronous exceptions done");
    {irqOn, fiqOn} = 2'b11;
    waitExc(a);
    entryCheck(exc_entry_pkg::ExcFiq, a + 32'h4);
    fiqOn = 1'b0;
    repeat (6) step();
    doReturn();
    waitExc(a);
    entryCheck(exc_entry_pkg::ExcIrq, a + 32'h4);
    irqOn = 1'b0;
    repeat (6) step();
    doReturn();
    $display("test interrupts done");
    copWilling = 1'b1;
    present(4'b0001, rnd());
    step();
    idle();
    waitAnswer();
    check("cop retire", {31'h0, instrRetire}, 32'h1);
    check("cop kind", {29'h0, excTaken}, {29'h0, exc_entry_pkg::ExcNone});
    copWilling = 1'b0;
    repeat (4) step();
    a = rnd();
    present(4'b0001, a);
    step();
    idle();
    waitAnswer();
    entryCheck(exc_entry_pkg::ExcUndef, a + 32'h4);
    doReturn();
    instr = {1'b0, rnd(), 4'b1000};
    step();
    idle();
    check("discarded abort", {29'h0, excTaken}, {29'h0, exc_entry_pkg::ExcNone});
    $display("test coprocessor and fetch abort done");
    present(4'b0001, rnd());
    step();
    idle();
    step();
    reset = 1'b1;
    repeat (2) step();
    reset = 1'b0;
    step();
    expStatus = exc_entry_pkg::StatusRst;
    entryCheck(exc_entry_pkg::ExcReset, 32'h0);
    $display("test reset in mid instruction done");
    report_and_stop();
  end
endmodule : processor_exception_entry_tb
